// [verilog/casd_pkg.sv]
// constants, field layouts and carrier types of the address-space decoder
// assumes a 24-bit byte address space and a 16-bit data path
//
// Overview of operation
// - standard register block is FE00..FFFF
// - extended register block is F000..F1FF
// - short offset reaches words and low bytes
// - byte write clears other register byte
// - upper half bit-addressable except top sixteen words
// - block switch redirects short and bit addresses
// - working registers resolve in both blocks
// - IO accesses bypass buffers and caches
// - IO reads wait for resolved speculation
// - IO read waits for pending IO writes
// - read-modify-write read waits for IO writes (rmw flag unused: only io-region reads wait)
// - external IO, register blocks, internal IO are IO
// - external IO bytes are true byte transfers
// - channel source low word, destination next word
// - channel pointers live on peripheral bus
// - pointer byte write clears other byte
// - unused channel pointers provide no storage
// - unclaimed addresses go to external bus
// - external alignment enforced, no bit addressing
// - segment 191 reads zero, writes dropped
// - segment 191 reachable only in boot modes
// - dual port RAM spans F200..FDFF
package casd_pkg;

    localparam logic [23:0] STD_REG_LO   = 24'h00_FE00; // standard register block
    localparam logic [23:0] STD_REG_HI   = 24'h00_FFFF;
    localparam logic [23:0] EXT_REG_LO   = 24'h00_F000; // extended register block
    localparam logic [23:0] EXT_REG_HI   = 24'h00_F1FF;
    localparam logic [23:0] DUAL_RAM_LO  = 24'h00_F200; // dual port data ram
    localparam logic [23:0] DUAL_RAM_HI  = 24'h00_FDFF;
    localparam logic [23:0] INT_IO_LO    = 24'h00_E000; // internal io window
    localparam logic [23:0] INT_IO_HI    = 24'h00_EFFF;
    localparam logic [23:0] EXT_IO_LO    = 24'h20_0000; // external io range
    localparam logic [23:0] EXT_IO_HI    = 24'h3F_FFFF;
    localparam logic [7:0]  BOOT_SEG     = 8'hBF;       // segment 191
    localparam logic [8:0]  BIT_HALF_LO  = 9'h100;      // upper half offset in block
    localparam logic [8:0]  BIT_HALF_HI  = 9'h1DF;      // below sixteen top words
    localparam logic [7:0]  GPR_SHORT_LO = 8'hF0;       // short codes naming working regs
    localparam logic [15:0] BOOT_READ_VAL = 16'h0000;
    localparam logic [2:0]  SWITCH_CNT_RST = 3'h0;

    // region classification
    typedef enum logic [2:0] {
        CASD_REG_STD,
        CASD_REG_EXT,
        CASD_INT_IO,
        CASD_EXT_IO,
        CASD_EXT_MEM,
        CASD_BOOT_SEG,
        CASD_DUAL_RAM,
        CASD_GPR
    } casd_region_t;

    // address mode of an access
    typedef enum logic [1:0] {
        CASD_MODE_LONG,
        CASD_MODE_INDIRECT,
        CASD_MODE_SHORT,
        CASD_MODE_BIT
    } casd_mode_t;

    // size of an access
    typedef enum logic [1:0] {
        CASD_SIZE_BYTE,
        CASD_SIZE_WORD,
        CASD_SIZE_DWORD
    } casd_size_t;

    // request from the core
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        rmw;     // read phase of a bit manipulation
        casd_mode_t  mode;
        casd_size_t  size;
        logic [23:0] addr;    // long address, or short offset in [7:0]
        logic [15:0] wdata;
    } casd_req_t;

    // issued access towards the buses
    typedef struct packed {
        logic         valid;
        logic         write;
        casd_region_t region;
        logic [23:0]  addr;
        logic [1:0]   byte_en;
        logic [15:0]  wdata;
        logic         io;
        logic         bypass;   // not buffered, not cached
        logic         periph;   // internal peripheral bus
        logic         ext_bus;  // external bus controller
        logic         bit_ok;
    } casd_acc_t;

endpackage : casd_pkg

// [verilog/casd_decoder.sv]
// address-space decoder and access policy for the 16-bit core
// assumes the core holds a request until REQ_READY_O is seen high, and
// that the pipeline reports speculation and pending io writes on the same clock
`timescale 1ns/1ps
`default_nettype none
module casd_decoder #(
    parameter int CHANNELS = 8,               // event transfer channels
    parameter logic [23:0] PTR_BASE = 24'h00_EC00 // pointer pairs in internal io
) (
    input  wire logic               CORE_CLK_I,
    input  wire logic               ARST_N_I,
    input  wire casd_pkg::casd_req_t REQ_I,
    input  wire logic               SPEC_PENDING_I,     // unresolved speculation
    input  wire logic               IO_WR_PENDING_I,    // io writes still in flight
    input  wire logic               BOOT_MODE_I,        // boot or emulation mode
    input  wire logic               SWITCH_START_I,     // block switch instruction
    input  wire logic [2:0]         SWITCH_COUNT_I,     // its instruction count minus one
    input  wire logic               INSTR_DONE_I,       // one instruction retired
    input  wire logic [7:0]         CHANNEL_USED_I,     // per channel in use
    input  wire logic [7:0]         CP_BASE_I,          // working register page base
    output logic                    REQ_READY_O,
    output casd_pkg::casd_acc_t     ACC_O,
    output logic                    ALIGN_ERR_O,
    output logic                    DENIED_O,           // access suppressed
    output logic [15:0]             BOOT_RDATA_O,
    output logic                    BOOT_RVALID_O
);
    // elaboration check: the used-channel mask is eight bits wide, and the
    // channel index is taken from address bits 4..2, so the base is 32-byte aligned
    if (CHANNELS < 1 || CHANNELS > 8 || PTR_BASE[4:0] != 5'h00) begin : g_bad_channels
        $error("CHANNELS must be 1..8 and PTR_BASE 32-byte aligned");
    end

    // block switch window state
    logic       sw_active;
    logic [2:0] sw_left;
    logic       next_sw_active;
    logic [2:0] next_sw_left;

    // registered outputs
    casd_pkg::casd_acc_t acc;
    casd_pkg::casd_acc_t next_acc;
    logic        ready, next_ready;
    logic        aerr, next_aerr;
    logic        denied, next_denied;
    logic [15:0] brdata, next_brdata;
    logic        brvalid, next_brvalid;

    // inclusive range check used by the region tests except segment 191 and working registers
    function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    // bit addressable zone inside a 512-byte register block
    function automatic logic bit_zone(input logic [8:0] off);
        bit_zone = (off >= casd_pkg::BIT_HALF_LO) && (off <= casd_pkg::BIT_HALF_HI);
    endfunction : bit_zone

    // block switch counter: redirection lasts for the stated instruction count
    always_comb begin
        next_sw_active = sw_active;
        next_sw_left   = sw_left;
        if (SWITCH_START_I) begin
            next_sw_active = 1'b1;
            next_sw_left   = SWITCH_COUNT_I;
        end else if (sw_active && INSTR_DONE_I) begin
            if (sw_left == 3'h0) begin
                next_sw_active = 1'b0;
            end else begin
                next_sw_left = sw_left - 3'h1;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sw_active <= 1'b0;
            sw_left   <= casd_pkg::SWITCH_CNT_RST;
        end else begin
            sw_active <= next_sw_active;
            sw_left   <= next_sw_left;
        end
    end

    // decode and policy: one access leaves per cycle, stalls hold it in the core
    always_comb begin
        logic [23:0] a;
        logic        short_m;
        logic        is_io;
        logic        stall;
        logic        ptr_hit;
        logic [3:0]  ptr_idx;
        casd_pkg::casd_region_t reg_cls;
        a       = REQ_I.addr;
        short_m = (REQ_I.mode == casd_pkg::CASD_MODE_SHORT) ||
                  (REQ_I.mode == casd_pkg::CASD_MODE_BIT);
        ptr_hit = 1'b0;
        ptr_idx = 4'h0;
        reg_cls = casd_pkg::CASD_EXT_MEM;
        is_io   = 1'b0;
        stall   = 1'b0;
        next_acc     = '0;
        next_aerr    = 1'b0;
        next_denied  = 1'b0;
        next_brdata  = casd_pkg::BOOT_READ_VAL;
        next_brvalid = 1'b0;

        // short forms: working registers first, then the selected block
        if (short_m && REQ_I.addr[7:0] >= casd_pkg::GPR_SHORT_LO) begin
            a = {16'h0000, CP_BASE_I} + {19'h0, REQ_I.addr[3:0], 1'b0};
        end else if (short_m) begin
            a = (sw_active ? casd_pkg::EXT_REG_LO : casd_pkg::STD_REG_LO)
                + {15'h0, REQ_I.addr[7:0], 1'b0};
        end

        // one class per access
        if (short_m && REQ_I.addr[7:0] >= casd_pkg::GPR_SHORT_LO) begin
            reg_cls = casd_pkg::CASD_GPR;
        end else if (in_rng(a, casd_pkg::STD_REG_LO, casd_pkg::STD_REG_HI)) begin
            reg_cls = casd_pkg::CASD_REG_STD;
        end else if (in_rng(a, casd_pkg::EXT_REG_LO, casd_pkg::EXT_REG_HI)) begin
            reg_cls = casd_pkg::CASD_REG_EXT;
        end else if (in_rng(a, casd_pkg::DUAL_RAM_LO, casd_pkg::DUAL_RAM_HI)) begin
            reg_cls = casd_pkg::CASD_DUAL_RAM;
        end else if (in_rng(a, casd_pkg::INT_IO_LO, casd_pkg::INT_IO_HI)) begin
            reg_cls = casd_pkg::CASD_INT_IO;
        end else if (a[23:16] == casd_pkg::BOOT_SEG) begin
            reg_cls = casd_pkg::CASD_BOOT_SEG;
        end else if (in_rng(a, casd_pkg::EXT_IO_LO, casd_pkg::EXT_IO_HI)) begin
            reg_cls = casd_pkg::CASD_EXT_IO;
        end else begin
            reg_cls = casd_pkg::CASD_EXT_MEM;
        end

        is_io = (reg_cls == casd_pkg::CASD_REG_STD) || (reg_cls == casd_pkg::CASD_REG_EXT)
             || (reg_cls == casd_pkg::CASD_INT_IO) || (reg_cls == casd_pkg::CASD_EXT_IO);

        // io reads wait for speculation and for pending io writes
        stall = REQ_I.valid && is_io && !REQ_I.write &&
                (SPEC_PENDING_I || IO_WR_PENDING_I);
        next_ready = !stall;

        // event transfer pointer pairs: source even word, destination odd word
        if (a >= PTR_BASE && a < PTR_BASE + 24'(CHANNELS * 4)) begin
            ptr_hit = 1'b1;
            ptr_idx = 4'(a[4:2]);
        end

        if (REQ_I.valid && !stall) begin
            next_acc.valid   = 1'b1;
            next_acc.write   = REQ_I.write;
            next_acc.region  = reg_cls;
            next_acc.addr    = a;
            next_acc.io      = is_io;
            next_acc.bypass  = is_io;
            next_acc.periph  = is_io && reg_cls != casd_pkg::CASD_EXT_IO;
            next_acc.ext_bus = (reg_cls == casd_pkg::CASD_EXT_IO)
                            || (reg_cls == casd_pkg::CASD_EXT_MEM);
            next_acc.byte_en = 2'b11;
            next_acc.wdata   = REQ_I.wdata;
            // bit addressing only in upper register halves and working registers
            next_acc.bit_ok = (reg_cls == casd_pkg::CASD_GPR) ||
                (((reg_cls == casd_pkg::CASD_REG_STD) || (reg_cls == casd_pkg::CASD_REG_EXT))
                 && bit_zone(a[8:0]));

            if (REQ_I.size == casd_pkg::CASD_SIZE_BYTE) begin
                if (reg_cls == casd_pkg::CASD_EXT_IO || reg_cls == casd_pkg::CASD_EXT_MEM) begin
                    next_acc.byte_en = a[0] ? 2'b10 : 2'b01;
                end else if (is_io && REQ_I.write) begin
                    // full word written: the other byte is forced to zero
                    next_acc.wdata = a[0] ? {REQ_I.wdata[7:0], 8'h00}
                                          : {8'h00, REQ_I.wdata[7:0]};
                end
            end

            // short offsets never reach high bytes
            if (short_m && REQ_I.size == casd_pkg::CASD_SIZE_BYTE && REQ_I.addr[8]) begin
                next_denied = 1'b1;
            end
            if (REQ_I.mode == casd_pkg::CASD_MODE_BIT && !next_acc.bit_ok) begin
                next_denied = 1'b1;
            end
            if (next_acc.ext_bus) begin
                if ((REQ_I.size == casd_pkg::CASD_SIZE_WORD && a[0]) ||
                    (REQ_I.size == casd_pkg::CASD_SIZE_DWORD && a[1:0] != 2'b00)) begin
                    next_aerr   = 1'b1;
                    next_denied = 1'b1;
                end
            end
            if (ptr_hit && !CHANNEL_USED_I[ptr_idx[2:0]]) begin
                next_denied = 1'b1;
            end
            if (reg_cls == casd_pkg::CASD_BOOT_SEG && !BOOT_MODE_I) begin
                next_denied  = 1'b1;
                next_brvalid = !REQ_I.write;
                next_brdata  = casd_pkg::BOOT_READ_VAL;
            end
            if (next_denied) begin
                next_acc.valid   = 1'b0;
                next_acc.ext_bus = 1'b0;
            end
        end
    end

    // output registers
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            acc     <= '0;
            ready   <= 1'b0;
            aerr    <= 1'b0;
            denied  <= 1'b0;
            brdata  <= casd_pkg::BOOT_READ_VAL;
            brvalid <= 1'b0;
        end else begin
            acc     <= next_acc;
            ready   <= next_ready;
            aerr    <= next_aerr;
            denied  <= next_denied;
            brdata  <= next_brdata;
            brvalid <= next_brvalid;
        end
    end

    assign REQ_READY_O   = ready;
    assign ACC_O         = acc;
    assign ALIGN_ERR_O   = aerr;
    assign DENIED_O      = denied;
    assign BOOT_RDATA_O  = brdata;
    assign BOOT_RVALID_O = brvalid;

endmodule : casd_decoder
`default_nettype wire

// [tb/casd_decoder_props.sv]
// concurrent checks on the ports of the address-space decoder
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module casd_decoder_props #(
    parameter int          CHANNELS = 8,
    parameter logic [23:0] PTR_BASE = 24'h00_EC00
) (
    input wire logic                CORE_CLK_I,
    input wire logic                ARST_N_I,
    input wire casd_pkg::casd_req_t REQ_I,
    input wire logic                SPEC_PENDING_I,
    input wire logic                IO_WR_PENDING_I,
    input wire logic                BOOT_MODE_I,
    input wire casd_pkg::casd_acc_t ACC_O,
    input wire logic                ALIGN_ERR_O,
    input wire logic                DENIED_O,
    input wire logic [15:0]         BOOT_RDATA_O,
    input wire logic                BOOT_RVALID_O
);
    // long access to plain external memory: never io, so never stalled
    logic xm;
    assign xm = REQ_I.valid && REQ_I.mode == casd_pkg::CASD_MODE_LONG
             && REQ_I.addr[23:20] == 4'h1;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    one_answer_a: assert property (xm |=> ACC_O.valid ^ DENIED_O)
        else $error("request without exactly one answer");
    ext_route_a: assert property (
        xm && REQ_I.addr[1:0] == 2'h0 |=> ACC_O.ext_bus && !ACC_O.bit_ok)
        else $error("external access misrouted");
    ext_align_a: assert property (
        xm && REQ_I.size == casd_pkg::CASD_SIZE_WORD && REQ_I.addr[0] |=> ALIGN_ERR_O)
        else $error("odd external word not flagged");
    // the io regions are named here from the map, not from the io flag itself
    io_bypass_a: assert property (ACC_O.valid && ACC_O.region inside {
        casd_pkg::CASD_REG_STD, casd_pkg::CASD_REG_EXT, casd_pkg::CASD_INT_IO,
        casd_pkg::CASD_EXT_IO} |-> ACC_O.io && ACC_O.bypass)
        else $error("io access buffered");
    spec_wait_a: assert property (
        ACC_O.valid && ACC_O.io && !ACC_O.write |-> !$past(SPEC_PENDING_I))
        else $error("io read under speculation");
    wr_wait_a: assert property (
        ACC_O.valid && ACC_O.io && !ACC_O.write |-> !$past(IO_WR_PENDING_I))
        else $error("io read passed pending write");
    int_io_a: assert property (ACC_O.valid && ACC_O.region == casd_pkg::CASD_INT_IO
        |-> ACC_O.io && ACC_O.periph && !ACC_O.ext_bus)
        else $error("internal io misrouted");
    top_words_a: assert property (ACC_O.valid && ACC_O.region == casd_pkg::CASD_REG_STD
        |-> ACC_O.io && ACC_O.bit_ok == (ACC_O.addr[8:1] inside {[8'h80:8'hEF]}))
        else $error("register bit zone wrong");
    boot_zero_a: assert property (BOOT_RVALID_O |-> DENIED_O && BOOT_RDATA_O == 16'h0000)
        else $error("boot read not zero");
    boot_gate_a: assert property (
        ACC_O.valid && ACC_O.region == casd_pkg::CASD_BOOT_SEG |-> $past(BOOT_MODE_I))
        else $error("boot segment reached outside boot mode");
    ext_cov_c: cover property (ACC_O.valid && ACC_O.ext_bus);
    deny_cov_c: cover property (DENIED_O);
    stall_cov_c: cover property (SPEC_PENDING_I && REQ_I.valid ##1 !ACC_O.valid);
    boot_cov_c: cover property (BOOT_RVALID_O);
endmodule : casd_decoder_props
bind casd_decoder casd_decoder_props #(.CHANNELS(CHANNELS), .PTR_BASE(PTR_BASE)) u_casd_decoder_props (
    .CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I), .REQ_I(REQ_I),
    .SPEC_PENDING_I(SPEC_PENDING_I), .IO_WR_PENDING_I(IO_WR_PENDING_I),
    .BOOT_MODE_I(BOOT_MODE_I), .ACC_O(ACC_O), .ALIGN_ERR_O(ALIGN_ERR_O),
    .DENIED_O(DENIED_O), .BOOT_RDATA_O(BOOT_RDATA_O), .BOOT_RVALID_O(BOOT_RVALID_O));
`default_nettype wire

// [tb/casd_bus_partner.sv]
// model of the peripheral bus and external bus controller side
// assumes it sees every issued access on the decoder's clock
`timescale 1ns/1ps
`default_nettype none
module casd_bus_partner (
    input  wire logic                clk_i,
    input  wire logic                arst_n_i,
    input  wire casd_pkg::casd_acc_t acc_i,
    output logic [7:0]               ext_seen_o,    // accesses reaching the pins
    output logic [7:0]               periph_seen_o  // peripheral bus accesses
);
    logic [7:0] next_ext_seen;
    logic [7:0] next_periph_seen;
    // count what each bus is handed; a suppressed access must never show
    always_comb begin
        next_ext_seen = ext_seen_o + {7'h00, acc_i.valid & acc_i.ext_bus};
        next_periph_seen = periph_seen_o + {7'h00, acc_i.valid & acc_i.periph};
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_seen_o <= 8'h00;
            periph_seen_o <= 8'h00;
        end else begin
            ext_seen_o <= next_ext_seen;
            periph_seen_o <= next_periph_seen;
        end
    end
endmodule : casd_bus_partner
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the address-space decoder
// assumes package, decoder, checker and partner are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module testbench;
    localparam casd_pkg::casd_mode_t LG = casd_pkg::CASD_MODE_LONG;
    localparam casd_pkg::casd_mode_t SH = casd_pkg::CASD_MODE_SHORT;
    localparam casd_pkg::casd_mode_t BT = casd_pkg::CASD_MODE_BIT;
    localparam casd_pkg::casd_mode_t ID = casd_pkg::CASD_MODE_INDIRECT;
    localparam casd_pkg::casd_size_t BY = casd_pkg::CASD_SIZE_BYTE;
    localparam casd_pkg::casd_size_t WD = casd_pkg::CASD_SIZE_WORD;
    // one table row: request fields, then expected region, io, lanes, data, bit zone
    typedef struct packed {
        casd_pkg::casd_mode_t m; casd_pkg::casd_size_t s; logic w; logic [23:0] a;
        logic [15:0] d; casd_pkg::casd_region_t r; logic io; logic [1:0] be;
        logic [15:0] ed; logic b; logic k; logic n;
    } casd_row_t;
    casd_row_t rows[17] = '{
        '{LG,WD,1,24'h00_F000,16'h1234,casd_pkg::CASD_REG_EXT,1,3,16'h1234,0,1,0},
        '{LG,WD,0,24'h00_FE00,0,casd_pkg::CASD_REG_STD,1,3,0,0,1,0},
        '{LG,WD,0,24'h00_FF00,0,casd_pkg::CASD_REG_STD,1,3,0,1,1,0},
        '{LG,WD,0,24'h00_FFE0,0,casd_pkg::CASD_REG_STD,1,3,0,0,1,0},
        '{LG,WD,0,24'h00_E000,0,casd_pkg::CASD_INT_IO,1,3,0,0,1,0},
        '{LG,BY,1,24'h00_FE01,16'h00AB,casd_pkg::CASD_REG_STD,1,3,16'hAB00,0,1,0},
        '{LG,BY,1,24'h00_EC00,16'h00CD,casd_pkg::CASD_INT_IO,1,3,16'h00CD,0,1,0},
        '{LG,BY,1,24'h00_EC03,16'h00EF,casd_pkg::CASD_INT_IO,1,3,16'hEF00,0,1,0},
        '{LG,BY,1,24'h20_0001,16'h0055,casd_pkg::CASD_EXT_IO,1,2,0,0,0,0},
        '{LG,WD,0,24'h10_0000,0,casd_pkg::CASD_EXT_MEM,0,3,0,0,1,0},
        '{LG,WD,0,24'h00_F200,0,casd_pkg::CASD_DUAL_RAM,0,3,0,0,0,0},
        '{SH,WD,0,24'h00_00F3,0,casd_pkg::CASD_GPR,0,3,0,0,0,0},
        '{LG,WD,1,24'h00_EC1C,16'h1111,casd_pkg::CASD_INT_IO,1,3,0,0,0,1},
        '{SH,BY,0,24'h00_0110,0,casd_pkg::CASD_REG_STD,1,3,0,0,0,1},
        '{LG,WD,0,24'hBF_0000,0,casd_pkg::CASD_BOOT_SEG,0,3,0,0,0,1},
        '{BT,WD,0,24'h00_0080,0,casd_pkg::CASD_REG_STD,1,3,0,0,0,0},
        '{BT,WD,0,24'h00_0000,0,casd_pkg::CASD_REG_STD,1,3,0,0,0,1}};
    logic                clk = 1'h0;
    logic                arst_n = 1'h0;
    casd_pkg::casd_req_t req = '0;
    casd_pkg::casd_req_t r;
    logic                spec = 1'h0;
    logic                iowr = 1'h0;
    logic                boot = 1'h0;
    logic                sw = 1'h0;
    logic [2:0]          swc = 3'h0;
    logic                done = 1'h0;
    casd_pkg::casd_acc_t acc;
    logic                rdy;
    logic                aerr;
    logic                den;
    logic                brv;
    logic [15:0]         brd;
    logic [7:0]          ext_n;
    logic [7:0]          per_n;
    logic [7:0]          n0;
    int                  n_errors = 0;
    int                  samples_checked = 0;
    always #12.5 clk = ~clk;
    casd_decoder u_casd_decoder (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .REQ_I(req),
        .SPEC_PENDING_I(spec), .IO_WR_PENDING_I(iowr), .BOOT_MODE_I(boot),
        .SWITCH_START_I(sw), .SWITCH_COUNT_I(swc), .INSTR_DONE_I(done),
        .CHANNEL_USED_I(8'h0F), .CP_BASE_I(8'hFC), .REQ_READY_O(rdy), .ACC_O(acc),
        .ALIGN_ERR_O(aerr), .DENIED_O(den), .BOOT_RDATA_O(brd), .BOOT_RVALID_O(brv));
    casd_bus_partner u_casd_bus_partner (.clk_i(clk), .arst_n_i(arst_n), .acc_i(acc),
        .ext_seen_o(ext_n), .periph_seen_o(per_n));
    function automatic casd_pkg::casd_req_t mk(casd_pkg::casd_mode_t m,
        casd_pkg::casd_size_t s, logic w, logic [23:0] a);
        mk = '{1'h1, w, 1'h0, m, s, a, rows[0].d};
    endfunction : mk
    // present one request for one edge, then look at the registered answer
    task automatic issue(input casd_pkg::casd_req_t q);
        @(posedge clk) req <= q;
        @(posedge clk) req <= '0;
        #1;
    endtask : issue
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clk);
        `CHK(acc, '0)
        @(posedge clk) arst_n <= 1'h1;
        foreach (rows[i]) begin
            r = mk(rows[i].m, rows[i].s, rows[i].w, rows[i].a);
            r.wdata = rows[i].d;
            issue(r);
            `CHK(den, rows[i].n)
            `CHK(acc.valid, !rows[i].n)
            if (!rows[i].n) begin
                `CHK(acc.region, rows[i].r)
                `CHK(acc.bypass, rows[i].io)
                `CHK(acc.byte_en, rows[i].be)
            end
            if (!rows[i].n && rows[i].k) begin
                `CHK(acc.addr, rows[i].a)
                `CHK(acc.bit_ok, rows[i].b)
                if (rows[i].w)
                    `CHK(acc.wdata, rows[i].ed)
            end
        end
        // bus partner totals after the table: eight register/internal io rows
        // plus the allowed bit row on the peripheral bus, two on the external bus
        `CHK(per_n, 8'h09)
        `CHK(ext_n, 8'h02)
        // block switch redirects short offsets for two retired instructions
        @(posedge clk) begin
            sw <= 1'h1;
            swc <= 3'h1;
        end
        @(posedge clk) sw <= 1'h0;
        issue(mk(SH, WD, 1'h0, 24'h00_0010));
        `CHK(acc.addr, 24'h00_F020)
        issue(mk(SH, WD, 1'h0, 24'h00_00F3));
        `CHK(acc.region, casd_pkg::CASD_GPR)
        issue(mk(ID, WD, 1'h0, 24'h00_FE20));
        `CHK(acc.region, casd_pkg::CASD_REG_STD)
        for (int j = 0; j < 2; j++) begin
            @(posedge clk) done <= 1'h1;
            @(posedge clk) done <= 1'h0;
            issue(mk(SH, WD, 1'h0, 24'h00_0010));
            `CHK(acc.addr, (j == 1) ? 24'h00_FE20 : 24'h00_F020)
        end
        // io read held while speculation, then pending writes, are open
        for (int i = 0; i < 2; i++) begin
            r = mk(LG, WD, 1'h0, 24'h00_E000);
            r.rmw = (i == 1);
            @(posedge clk) begin
                spec <= (i == 0);
                iowr <= (i == 1);
                req <= r;
            end
            repeat (3) @(posedge clk);
            #1;
            `CHK(acc.valid, 1'h0)
            `CHK(rdy, 1'h0)
            @(posedge clk) begin
                spec <= 1'h0;
                iowr <= 1'h0;
            end
            // the held request is taken at the next edge, then dropped
            @(posedge clk) req <= '0;
            #1;
            `CHK(acc.valid, 1'h1)
            `CHK(rdy, 1'h1)
        end
        n0 = ext_n;
        issue(mk(LG, WD, 1'h0, 24'hBF_0010));
        `CHK(brv, 1'h1)
        issue(mk(LG, WD, 1'h1, 24'hBF_0010));
        `CHK(den, 1'h1)
        @(posedge clk) boot <= 1'h1;
        #1;
        `CHK(ext_n, n0)
        issue(mk(LG, WD, 1'h0, 24'hBF_0010));
        `CHK(acc.region, casd_pkg::CASD_BOOT_SEG)
        issue(mk(LG, WD, 1'h0, 24'h10_0001));
        `CHK(aerr, 1'h1)
        issue(mk(LG, casd_pkg::CASD_SIZE_DWORD, 1'h0, 24'h10_0002));
        `CHK(aerr, 1'h1)
        issue(mk(LG, casd_pkg::CASD_SIZE_DWORD, 1'h0, 24'h10_0004));
        `CHK(aerr, 1'h0)
        // mid-run reset: a live block switch and every output must clear
        @(posedge clk) sw <= 1'h1;
        @(posedge clk) begin
            sw <= 1'h0;
            arst_n <= 1'h0;
        end
        #1;
        `CHK(acc, '0)
        `CHK({rdy, aerr, den, brv, brd}, 20'h0_0000)
        @(posedge clk) arst_n <= 1'h1;
        issue(mk(SH, WD, 1'h0, 24'h00_0010));
        `CHK(acc.addr, 24'h00_FE20)
        final_report();
    end
endmodule : testbench
`default_nettype wire
